// ==== dv/rtcth_analog_model.sv ====
`timescale 1ns/10ps
// ==========================================================
// far side: crystal oscillator and supply comparators
module rtcth_analog_model (
  // clock
  input wire logic aclk,
  // stimulus from the bench
  input wire logic osc_run,
  input wire logic [11:0] supply_mv,
  // towards the block
  output logic osc_clk_in,
  output logic supply_below_hi_in,
  output logic supply_below_lo_in
);
  // a stopped crystal freezes at its last level, it does not return to idle
  initial osc_clk_in = 1'b0;
  always @(posedge aclk) begin
    if (osc_run) begin
      osc_clk_in <= ~osc_clk_in;
    end
  end
  assign supply_below_hi_in = (supply_mv < 12'h834);
  assign supply_below_lo_in = (supply_mv < 12'h640);
endmodule // rtcth_analog_model

// ==== dv/tb_rtc_time_trim_and_halt_flags.sv ====
`timescale 1ns/10ps
`include "rtcth_regs.svh"
module tb_rtc_time_trim_and_halt_flags
  import rtcth_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, osc_clk_in, supply_below_hi_in;
  logic supply_below_lo_in, supply_sample_en, raw_clock_out, raw_clock_oe_n, periodic_event;
  logic weekly_alarm_event, daily_alarm_event, second_tick, osc_run, prev;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [11:0] supply_mv;
  logic [7:0] d;
  rtcth_ctrl1_s ctrl1_o;
  rtcth_ctrl2_s ctrl2_o;
  int mismatches = 0, total_checks = 0, seed = 81600, cyc = 0, i, n;

  // ==========================================================
  // design and far side
  rtcth_trim_halt #(.HALT_CYCLES(50), .SAMPLE_CYCLES(20)) u_rtcth_trim_halt (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .osc_clk_in, .supply_below_hi_in, .supply_below_lo_in, .supply_sample_en, .raw_clock_out,
    .raw_clock_oe_n, .periodic_event, .weekly_alarm_event, .daily_alarm_event, .second_tick,
    .ctrl1_o, .ctrl2_o
  );
  rtcth_analog_model u_rtcth_analog_model (
    .aclk, .osc_run, .supply_mv, .osc_clk_in, .supply_below_hi_in, .supply_below_lo_in
  );

  // ==========================================================
  // checking and bus tasks
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      mismatches++;
    end
  endtask

  // sampling on the falling edge sees exactly what the next rising edge will take
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic aw_t, w_t, b_t;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw_t = s_axi_awvalid && s_axi_awready;
      w_t = s_axi_wvalid && s_axi_wready;
      b_t = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
    end while (!b_t);
  endtask

  task automatic axi_rd(input logic [3:0] a);
    logic ar_t, r_t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ar_t = s_axi_arvalid && s_axi_arready;
      r_t = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ar_t) s_axi_arvalid <= 1'b0;
    end while (!r_t);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    axi_rd(a);
    check(rd, exp);
  endtask

  // ==========================================================
  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      mismatches++;
      report_and_stop();
    end
  end

  // ==========================================================
  // main sequence
  // limitation: a 20-second trim period cannot fit the run, so trim codes are checked for storage only
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, periodic_event, weekly_alarm_event, daily_alarm_event} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    osc_run = 1'b1;
    supply_mv = 12'hBB8;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd_chk(`RTCTH_CTRL2_OFS, 32'h20);
    axi_wr(`RTCTH_TRIM_OFS, 32'h7F);
    axi_wr(`RTCTH_CTRL1_OFS, 32'hFF);
    rd_chk(`RTCTH_TRIM_OFS, 32'h00);
    rd_chk(`RTCTH_CTRL1_OFS, 32'h00);
    axi_wr(`RTCTH_CTRL2_OFS, 32'h00);
    rd_chk(`RTCTH_CTRL2_OFS, 32'h00);
    for (i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      axi_wr(`RTCTH_CTRL1_OFS, {24'h0, d});
      rd_chk(`RTCTH_CTRL1_OFS, {24'h0, d});
      check(ctrl1_o, {24'h0, d});
    end
    axi_wr(`RTCTH_TRIM_OFS, 32'h09);
    rd_chk(`RTCTH_TRIM_OFS, 32'h09);
    axi_wr(`RTCTH_TRIM_OFS, 32'h40);
    rd_chk(`RTCTH_TRIM_OFS, 32'h40);
    axi_wr(`RTCTH_TRIM_OFS, 32'h57);
    rd_chk(`RTCTH_TRIM_OFS, 32'h57);
    // writing ones to the flags must not set them
    axi_wr(`RTCTH_CTRL2_OFS, 32'hFF);
    rd_chk(`RTCTH_CTRL2_OFS, 32'h98);
    @(posedge aclk);
    {periodic_event, weekly_alarm_event, daily_alarm_event} <= 3'h7;
    @(posedge aclk);
    {periodic_event, weekly_alarm_event, daily_alarm_event} <= 3'h0;
    rd_chk(`RTCTH_CTRL2_OFS, 32'h9F);
    axi_wr(`RTCTH_CTRL2_OFS, 32'h98);
    rd_chk(`RTCTH_CTRL2_OFS, 32'h98);
    axi_wr(`RTCTH_CTRL2_OFS, 32'h00);
    axi_wr(4'hC, 32'h0);
    check(rsp, 2'h2);
    axi_rd(4'hC);
    check(rd, 32'h00000000);
    check(rsp, 2'h2);
    // the raw clock keeps toggling every cycle with a trim code loaded
    n = 0;
    // take the reference level where it has settled, not in the launching edge's time step
    @(negedge aclk);
    prev = raw_clock_oe_n;
    for (i = 0; i < 20; i++) begin
      @(negedge aclk);
      n += (raw_clock_oe_n !== prev);
      prev = raw_clock_oe_n;
      check(raw_clock_out, 1'b0);
    end
    check(n, 20);
    // 1.9 V lies between the two thresholds: only the 2.1 V one flags it
    @(posedge aclk);
    supply_mv <= 12'h76C;
    i = 0;
    do begin
      @(negedge aclk);
      i++;
    end while (second_tick !== 1'b1 && i < 70000);
    check(i < 70000, 1'b1);
    // the window closes at the edge that records the drop, so look in its first cycle
    repeat (1) @(negedge aclk);
    check(supply_sample_en, 1'b1);
    repeat (30) @(negedge aclk);
    check(ctrl2_o, 32'h40);
    check(supply_sample_en, 1'b0);
    @(posedge aclk);
    osc_run <= 1'b0;
    repeat (70) @(negedge aclk);
    check(ctrl2_o, 32'h20);
    check(ctrl1_o, 32'h00);
    @(posedge aclk);
    osc_run <= 1'b1;
    rd_chk(`RTCTH_TRIM_OFS, 32'h00);
    repeat (20) @(negedge aclk);
    check(ctrl2_o, 32'h20);
    report_and_stop();
  end
endmodule // tb_rtc_time_trim_and_halt_flags

// ==== hdl/rtcth_pkg.sv ====
package rtcth_pkg;

  typedef struct packed {
    logic weekly_alarm_enable;
    logic daily_alarm_enable;
    logic clock_out_enable_b;
    logic hour_format;
    logic test_mode;
    logic periodic_select_2;
    logic periodic_select_1;
    logic periodic_select_0;
  } rtcth_ctrl1_s;

  typedef struct packed {
    logic threshold_select;
    logic supply_drop_flag;
    logic osc_halt_flag;
    logic scratch;
    logic clock_out_enable_a;
    logic periodic_irq_flag;
    logic weekly_alarm_flag;
    logic daily_alarm_flag;
  } rtcth_ctrl2_s;

  typedef enum logic {
    MON_IDLE,
    MON_SAMPLE
  } rtcth_mon_e;

endpackage

// ==== hdl/rtcth_regs.svh ====
// Function
// - trim one second tick every 20 seconds
// - codes 0, +1, -64, -63 apply no correction
// - codes 02h..3Fh slow count, 3.05 ppm steps
// - codes 7Fh..42h speed count, 3.05 ppm steps
// - raw clock output ignores trim code
// - oscillator stop sets halt flag
// - supply below selected threshold sets drop flag
// - flags stay set until host writes zero
// - halt flag forces supply-drop flag to zero
// - halt clears trim, control and event flags
// - power-up from zero sets halt flag
// - threshold select 0 picks 2.1 V, 1 picks 1.6 V
// - sample supply 7.8 ms per second, stop once flagged
`ifndef RTCTH_REGS_SVH
`define RTCTH_REGS_SVH

// ==========================================================
// register offsets
`define RTCTH_TRIM_OFS 4'h0
`define RTCTH_CTRL1_OFS 4'h4
`define RTCTH_CTRL2_OFS 4'h8

// ==========================================================
// control 2 field positions
`define RTCTH_C2_SUPPLY_BIT 6
`define RTCTH_C2_HALT_BIT 5
`define RTCTH_C2_PIRQ_BIT 2
`define RTCTH_C2_WALM_BIT 1
`define RTCTH_C2_DALM_BIT 0

// ==========================================================
// reset values
`define RTCTH_TRIM_RST 7'h00
`define RTCTH_HALT_RST 1'b1

// ==========================================================
// timing
`define RTCTH_CLK_PERIOD_NS 20
`define RTCTH_HALT_TIME_NS 100000
`define RTCTH_SAMPLE_TIME_NS 7800000
`define RTCTH_SUBCOUNTS 32768
`define RTCTH_TRIM_PERIOD_S 20

`endif

// ==== hdl/rtcth_sync2.sv ====
`timescale 1ns/10ps
module rtcth_sync2 (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;

  // the first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule // rtcth_sync2

// ==== hdl/rtcth_trim_halt.sv ====
`timescale 1ns/10ps
`include "rtcth_regs.svh"
module rtcth_trim_halt
  import rtcth_pkg::*;
#(
  parameter int unsigned ADDR_W = 4,
  parameter int unsigned HALT_CYCLES = `RTCTH_HALT_TIME_NS / `RTCTH_CLK_PERIOD_NS,
  parameter int unsigned SAMPLE_CYCLES = `RTCTH_SAMPLE_TIME_NS / `RTCTH_CLK_PERIOD_NS
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // analog side pins
  input wire logic osc_clk_in,
  input wire logic supply_below_hi_in,
  input wire logic supply_below_lo_in,
  output logic supply_sample_en,
  // open-drain raw clock pin
  output logic raw_clock_out,
  output logic raw_clock_oe_n,
  // events from the counters and alarms
  input wire logic periodic_event,
  input wire logic weekly_alarm_event,
  input wire logic daily_alarm_event,
  // timekeeping and control towards the counters
  output logic second_tick,
  output rtcth_ctrl1_s ctrl1_o,
  output rtcth_ctrl2_s ctrl2_o
);

  // ==========================================================
  // pin synchronisers
  logic osc_s;
  logic below_hi_s;
  logic below_lo_s;

  rtcth_sync2 u_sync_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(osc_clk_in),
    .sync_out(osc_s)
  );

  rtcth_sync2 u_sync_hi (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(supply_below_hi_in),
    .sync_out(below_hi_s)
  );

  rtcth_sync2 u_sync_lo (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(supply_below_lo_in),
    .sync_out(below_lo_s)
  );

  // ==========================================================
  // axi4-lite slave
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  logic aw_full_r;
  logic w_full_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_en;
  logic wr_hit;
  logic [6:0] trim_r;
  rtcth_ctrl1_s ctrl1_r;
  rtcth_ctrl2_s ctrl2;

  assign s_axi_awready = !aw_full_r && !s_axi_bvalid;
  assign s_axi_wready = !w_full_r && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // both halves held: commit in this cycle, answer on the next edge
  assign wr_en = aw_full_r && w_full_r && !s_axi_bvalid;
  assign wr_hit = wr_en && wstrb_r[0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      awaddr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_en) begin
      w_full_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      unique case (awaddr_r)
        `RTCTH_TRIM_OFS, `RTCTH_CTRL1_OFS, `RTCTH_CTRL2_OFS: s_axi_bresp <= RESP_OKAY;
        default: s_axi_bresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case (s_axi_araddr)
        `RTCTH_TRIM_OFS: s_axi_rdata <= {25'h0000000, trim_r};
        `RTCTH_CTRL1_OFS: s_axi_rdata <= {24'h000000, ctrl1_r};
        `RTCTH_CTRL2_OFS: s_axi_rdata <= {24'h000000, ctrl2};
        default: begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // oscillator edge and halt detection
  logic osc_q_r;
  logic osc_rise;
  logic [$clog2(HALT_CYCLES+1)-1:0] stall_cnt_r;
  logic halt_event;

  assign osc_rise = osc_s && !osc_q_r;
  assign halt_event = (stall_cnt_r == ($bits(stall_cnt_r))'(HALT_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_q_r <= 1'b0;
    end else begin
      osc_q_r <= osc_s;
    end
  end

  // saturates one past the limit so a dead crystal raises a single event
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_cnt_r <= '0;
    end else if (osc_rise) begin
      stall_cnt_r <= '0;
    end else if (stall_cnt_r != ($bits(stall_cnt_r))'(HALT_CYCLES)) begin
      stall_cnt_r <= stall_cnt_r + 1'b1;
    end
  end

  // ==========================================================
  // flags and control registers
  logic halt_r;
  logic supply_r;
  logic thresh_r;
  logic scratch_r;
  logic clk_en_a_r;
  logic pirq_r;
  logic walm_r;
  logic dalm_r;
  logic c2_wr;
  logic drop_event;

  assign c2_wr = wr_hit && (awaddr_r == `RTCTH_CTRL2_OFS);

  // power-up from zero comes through reset; a stall event wins over a write of zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      halt_r <= `RTCTH_HALT_RST;
    end else if (halt_event) begin
      halt_r <= 1'b1;
    end else if (c2_wr && !wdata_r[`RTCTH_C2_HALT_BIT]) begin
      halt_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || halt_r) begin
      supply_r <= 1'b0;
    end else if (drop_event) begin
      supply_r <= 1'b1;
    end else if (c2_wr && !wdata_r[`RTCTH_C2_SUPPLY_BIT]) begin
      supply_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || halt_r) begin
      pirq_r <= 1'b0;
      walm_r <= 1'b0;
      dalm_r <= 1'b0;
    end else begin
      pirq_r <= periodic_event || (pirq_r && !(c2_wr && !wdata_r[`RTCTH_C2_PIRQ_BIT]));
      walm_r <= weekly_alarm_event || (walm_r && !(c2_wr && !wdata_r[`RTCTH_C2_WALM_BIT]));
      dalm_r <= daily_alarm_event || (dalm_r && !(c2_wr && !wdata_r[`RTCTH_C2_DALM_BIT]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || halt_r) begin
      thresh_r <= 1'b0;
      scratch_r <= 1'b0;
      clk_en_a_r <= 1'b0;
    end else if (c2_wr) begin
      thresh_r <= wdata_r[7];
      scratch_r <= wdata_r[4];
      clk_en_a_r <= wdata_r[3];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || halt_r) begin
      ctrl1_r <= '0;
    end else if (wr_hit && awaddr_r == `RTCTH_CTRL1_OFS) begin
      ctrl1_r <= rtcth_ctrl1_s'(wdata_r[7:0]);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || halt_r) begin
      trim_r <= `RTCTH_TRIM_RST;
    end else if (wr_hit && awaddr_r == `RTCTH_TRIM_OFS) begin
      trim_r <= wdata_r[6:0];
    end
  end

  always_comb begin
    ctrl2 = '{thresh_r, supply_r, halt_r, scratch_r, clk_en_a_r, pirq_r, walm_r, dalm_r};
  end

  assign ctrl1_o = ctrl1_r;
  assign ctrl2_o = ctrl2;

  // ==========================================================
  // supply monitor
  rtcth_mon_e mon_r;
  logic [$clog2(SAMPLE_CYCLES+1)-1:0] win_cnt_r;
  logic below_sel;

  // 0 compares against the 2.1 V level, 1 against 1.6 V
  assign below_sel = thresh_r ? below_lo_s : below_hi_s;
  assign drop_event = (mon_r == MON_SAMPLE) && below_sel && !supply_r;
  assign supply_sample_en = (mon_r == MON_SAMPLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mon_r <= MON_IDLE;
      win_cnt_r <= '0;
    end else begin
      unique case (mon_r)
        MON_IDLE: begin
          if (second_tick && !supply_r && !halt_r) begin
            mon_r <= MON_SAMPLE;
            win_cnt_r <= ($bits(win_cnt_r))'(SAMPLE_CYCLES - 1);
          end
        end
        MON_SAMPLE: begin
          // once flagged the monitor rests to save supply current
          if (drop_event || halt_r || win_cnt_r == '0) begin
            mon_r <= MON_IDLE;
          end else begin
            win_cnt_r <= win_cnt_r - 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // trimmed prescaler
  logic [15:0] sub_cnt_r;
  logic [4:0] sec20_r;
  logic corr_sec;
  logic [15:0] corr_len;

  // each code step is two sub-counts over 20 s, about 3.05 ppm
  function automatic logic [15:0] trim_len(input logic [6:0] code);
    logic [15:0] n;
    logic [6:0] mag;
    n = 16'(`RTCTH_SUBCOUNTS - 1);
    mag = 7'h00 - code;
    if (code[5:1] != 5'h00) begin
      if (!code[6]) begin
        n = n + 16'({code[5:0] - 6'h01, 1'b0});
      end else begin
        n = n - 16'({mag, 1'b0});
      end
    end
    return n;
  endfunction

  assign corr_sec = (sec20_r == 5'(`RTCTH_TRIM_PERIOD_S - 1));
  assign corr_len = trim_len(trim_r);
  // counts only crystal edges, so a stopped crystal also stops time
  assign second_tick = osc_rise && (sub_cnt_r == 16'h0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sub_cnt_r <= 16'(`RTCTH_SUBCOUNTS - 1);
    end else if (second_tick) begin
      sub_cnt_r <= corr_sec ? corr_len : 16'(`RTCTH_SUBCOUNTS - 1);
    end else if (osc_rise) begin
      sub_cnt_r <= sub_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sec20_r <= 5'h00;
    end else if (second_tick) begin
      sec20_r <= corr_sec ? 5'h00 : sec20_r + 5'h01;
    end
  end

  // ==========================================================
  // raw clock pin, fed straight from the crystal and never trimmed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      raw_clock_oe_n <= 1'b1;
    end else begin
      raw_clock_oe_n <= !((!clk_en_a_r || !ctrl1_r.clock_out_enable_b) && !osc_s);
    end
  end

  assign raw_clock_out = 1'b0;

  // ==========================================================
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  halt_at_reset_a: assert property ($past(aresetn) == 1'b0 |-> halt_r)
    else $error("halt flag not set after reset");

  halt_set_a: assert property (halt_event |=> halt_r)
    else $error("halt flag missed a stalled crystal");

  halt_clears_a: assert property (halt_r |=> trim_r == 7'h00 && ctrl1_r == '0 && !pirq_r && !thresh_r)
    else $error("halt did not clear control state");

  supply_forced_a: assert property (halt_r |=> !supply_r)
    else $error("supply flag survived halt");

  supply_sticky_a: assert property (supply_r && !halt_r && !c2_wr |=> supply_r)
    else $error("supply flag dropped without a write");

  supply_set_a: assert property (drop_event && !halt_r |=> supply_r)
    else $error("supply drop not recorded");

  sample_stop_a: assert property (supply_r |-> mon_r == MON_IDLE)
    else $error("monitor samples after drop flagged");

  no_trim_a: assert property (second_tick && corr_sec && trim_r[5:1] == 5'h00
                              |=> sub_cnt_r == 16'(`RTCTH_SUBCOUNTS - 1))
    else $error("neutral code changed the second");

  slow_trim_a: assert property (second_tick && corr_sec && !trim_r[6] && trim_r[5:1] != 5'h00
                                |=> sub_cnt_r == 16'(`RTCTH_SUBCOUNTS - 1) + 16'({$past(trim_r[5:0]) - 6'h01, 1'b0}))
    else $error("slow code gave wrong second length");

  plain_second_a: assert property (second_tick && !corr_sec |=> sub_cnt_r == 16'(`RTCTH_SUBCOUNTS - 1))
    else $error("untrimmed second has wrong length");

endmodule // rtcth_trim_halt
